// file: design/fwsr_host.sv
// Host controller that issues program and erase commands and polls their status.
//
// What the document requires of the host and of the device
// (R1) Device inverts written polling bit while programming.
// (R2) Host reads status at the programmed address.
// (R3) Protected program: polling active about 1 us; the model ends it after PROT_READS (3) status reads.
// (R4) Erase reads polling 0, then 1.
// (R5) Host reads erase status inside selected sector.
// (R6) All-protected erase: status about 3 ms; the model gives status for only PROT_READS (3) reads.
// (R7) Partly protected erase skips protected sectors.
// (R8) Status valid from final write strobe edge.
// (R9) Array data only from a later read.
// (R10) Ready/busy low while erasing or programming.
// (R11) Timeout flag set keeps ready/busy low.
// (R12) Toggle bit one inverts each read while busy.
// (R13) Toggle bit one valid from final strobe.
// (R14) Toggle stops in suspend, resumes for programming.
// (R15) Protected program toggles about 1 us; the model stops toggling after PROT_READS (3) status reads.
// (R16) Toggle bit two flags erase-selected sectors.
// (R17) Two reads; unchanged toggle means complete.
// (R18) Toggling with timeout: recheck, failure issues reset.
// (R19) Resumed monitoring restarts from two reads.
// (R20) Device sets timeout flag past pulse limit.
// (R21) Programming one over zero ends in timeout.
// (R22) After timeout failure host writes reset command.
// (R23) Suspended-sector reads give status bits.
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module fwsr_host (
	input wire logic core_clk, // System clock, 100 MHz.
	input wire logic rst, // Asynchronous reset, active high.
	input wire logic [7:0] sw_addr, // Register byte address.
	input wire logic [31:0] sw_wdata, // Register write data.
	input wire logic sw_wr, // Register write strobe.
	input wire logic sw_rd, // Register read strobe.
	output logic [31:0] sw_rdata, // Register read data, one cycle after the strobe.
	output logic [21:0] flash_addr, // Flash address pins.
	output logic [15:0] flash_dq_o, // Flash data, driven value.
	output logic flash_dq_oe, // Flash data, output enable.
	input wire logic [15:0] flash_dq_i, // Flash data, sensed value.
	output logic flash_ce_n, // Flash chip enable.
	output logic flash_oe_n, // Flash output enable.
	output logic flash_we_n, // Flash write enable.
	input wire logic ready_busy_n // Flash ready/busy line, low while busy.
);
	import fwsr_pkg::*;

	typedef enum logic [3:0] {
		ST_IDLE, ST_CMD, ST_POLL_A, ST_POLL_B, ST_RECHK_A, ST_RECHK_B, ST_FETCH, ST_RESET, ST_PAUSE
	} fwsr_st_t;
	fwsr_cyc_if cyc ();
	fwsr_op_t op_r;
	logic [3:0] st_r;
	logic [2:0] step_r;
	logic req_r;
	logic tog_r;
	logic hold_r;
	logic done_r;
	logic fail_r;
	logic [21:0] op_addr_r;
	logic [15:0] data_r;
	logic rb_s1_r;
	logic rb_s2_r;
	logic [38:0] step_w;
	logic cur_tog;
	logic same_tog;
	logic start;

	// --------------------------------------------------------------
	// Command sequences
	// --------------------------------------------------------------
	// Returns {last, address, data} of one write step of a command.
	function automatic logic [38:0] fwsr_step(input fwsr_op_t op, input logic [2:0] idx,
		input logic [21:0] pa, input logic [15:0] pd);
		logic [38:0] s;
		s = {1'b1, ADDR_RST, CMD_RESET};
		if (op == OP_PROGRAM) begin
			case (idx)
				3'h0: s = {1'b0, UNLOCK_A1, UNLOCK_D1};
				3'h1: s = {1'b0, UNLOCK_A2, UNLOCK_D2};
				3'h2: s = {1'b0, UNLOCK_A1, CMD_PROGRAM};
				default: s = {1'b1, pa, pd};
			endcase
		end else if (op == OP_ERASE) begin
			case (idx)
				3'h0, 3'h3: s = {1'b0, UNLOCK_A1, UNLOCK_D1};
				3'h1, 3'h4: s = {1'b0, UNLOCK_A2, UNLOCK_D2};
				3'h2: s = {1'b0, UNLOCK_A1, CMD_ERASE_SETUP};
				default: s = {1'b1, pa, CMD_SECTOR_ERASE};
			endcase
		end
		return s;
	endfunction : fwsr_step

	assign step_w = fwsr_step(op_r, step_r, op_addr_r, data_r);
	assign cur_tog = cyc.rdata[TOGGLE_BIT_ONE_POS];
	assign same_tog = (cur_tog == tog_r);
	assign start = sw_wr && (sw_addr == REG_CTRL) && sw_wdata[CTRL_GO_BIT] && (st_r == 4'(ST_IDLE));

	// Polls and fetches use the operation's own address. // see (R2) // see (R5)
	assign cyc.req = req_r;
	assign cyc.wr = (st_r == 4'(ST_CMD)) || (st_r == 4'(ST_RESET));
	assign cyc.addr = (st_r == 4'(ST_CMD)) ? step_w[37:16] :
		(st_r == 4'(ST_RESET)) ? ADDR_RST : op_addr_r;
	assign cyc.wdata = (st_r == 4'(ST_CMD)) ? step_w[15:0] : CMD_RESET;

	fwsr_bus_cycle u_cycle (
		.core_clk(core_clk),
		.rst(rst),
		.cyc(cyc),
		.flash_addr(flash_addr),
		.flash_dq_o(flash_dq_o),
		.flash_dq_oe(flash_dq_oe),
		.flash_dq_i(flash_dq_i),
		.flash_ce_n(flash_ce_n),
		.flash_oe_n(flash_oe_n),
		.flash_we_n(flash_we_n)
	);

	// --------------------------------------------------------------
	// Sequencer
	// --------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_r <= 4'(ST_IDLE);
			step_r <= 3'h0;
			req_r <= 1'b0;
			tog_r <= 1'b0;
		end else begin
			req_r <= 1'b0;
			case (st_r)
				4'(ST_IDLE): begin
					step_r <= 3'h0;
					if (start) begin
						req_r <= 1'b1;
						st_r <= (fwsr_op_t'(sw_wdata[CTRL_OP_LSB +: 2]) == OP_READ) ?
							4'(ST_FETCH) : 4'(ST_CMD);
					end
				end
				4'(ST_CMD): begin
					if (cyc.done) begin
						step_r <= step_r + 3'h1;
						if (!step_w[38]) begin
							req_r <= 1'b1;
						end else if (op_r != OP_RESET) begin
							req_r <= 1'b1;
							st_r <= 4'(ST_POLL_A); // see (R8) // see (R13)
						end else begin
							st_r <= 4'(ST_IDLE);
						end
					end
				end
				4'(ST_POLL_A), 4'(ST_RECHK_A): begin
					if (cyc.done) begin
						tog_r <= cur_tog;
						req_r <= 1'b1;
						st_r <= (st_r == 4'(ST_POLL_A)) ? 4'(ST_POLL_B) : 4'(ST_RECHK_B);
					end
				end
				4'(ST_POLL_B): begin
					if (cyc.done) begin
						if (same_tog) begin
							req_r <= 1'b1;
							st_r <= 4'(ST_FETCH); // see (R17) // see (R9)
						end else if (cyc.rdata[TIMEOUT_EXCEEDED_POS]) begin
							req_r <= 1'b1;
							st_r <= 4'(ST_RECHK_A); // see (R18)
						end else if (hold_r) begin
							st_r <= 4'(ST_PAUSE);
						end else begin
							req_r <= 1'b1;
							st_r <= 4'(ST_POLL_A);
						end
					end
				end
				4'(ST_RECHK_B): begin
					if (cyc.done) begin
						req_r <= 1'b1;
						st_r <= same_tog ? 4'(ST_FETCH) : 4'(ST_RESET); // see (R18) // see (R22)
					end
				end
				4'(ST_PAUSE): begin
					if (!hold_r) begin
						req_r <= 1'b1;
						st_r <= 4'(ST_POLL_A); // see (R19)
					end
				end
				4'(ST_FETCH), 4'(ST_RESET): begin
					if (cyc.done) begin
						st_r <= 4'(ST_IDLE);
					end
				end
				default: st_r <= 4'(ST_IDLE);
			endcase
		end
	end

	// --------------------------------------------------------------
	// Outcome flags and data
	// --------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			done_r <= 1'b0;
			fail_r <= 1'b0;
			op_r <= OP_READ;
			op_addr_r <= ADDR_RST;
			data_r <= DATA_RST;
		end else begin
			if (start) begin
				done_r <= 1'b0;
				fail_r <= 1'b0;
				op_r <= fwsr_op_t'(sw_wdata[CTRL_OP_LSB +: 2]);
			end
			if (sw_wr && (sw_addr == REG_ADDR) && (st_r == 4'(ST_IDLE))) begin
				op_addr_r <= sw_wdata[21:0];
			end
			if (sw_wr && (sw_addr == REG_DATA) && (st_r == 4'(ST_IDLE))) begin
				data_r <= sw_wdata[15:0];
			end
			if (cyc.done && (st_r == 4'(ST_FETCH))) begin
				data_r <= cyc.rdata;
				done_r <= 1'b1;
			end
			if (cyc.done && (st_r == 4'(ST_RESET))) begin
				fail_r <= 1'b1;
				done_r <= 1'b1;
			end
			if (cyc.done && (st_r == 4'(ST_CMD)) && step_w[38] && (op_r == OP_RESET)) begin
				done_r <= 1'b1;
			end
		end
	end

	// --------------------------------------------------------------
	// Software registers
	// --------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			hold_r <= 1'b0;
		end else if (sw_wr && (sw_addr == REG_CTRL)) begin
			hold_r <= sw_wdata[CTRL_HOLD_BIT];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rb_s1_r <= 1'b1;
			rb_s2_r <= 1'b1;
		end else begin
			rb_s1_r <= ready_busy_n;
			rb_s2_r <= rb_s1_r;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sw_rdata <= 32'h0000_0000;
		end else begin
			sw_rdata <= 32'h0000_0000;
			if (sw_rd) begin
				case (sw_addr)
					REG_CTRL: sw_rdata <= {27'h0, hold_r, 2'h0, 2'(op_r)};
					REG_ADDR: sw_rdata <= {10'h000, op_addr_r};
					REG_DATA: sw_rdata <= {16'h0000, data_r};
					REG_STAT: sw_rdata <= {27'h0, hold_r, rb_s2_r, fail_r, done_r,
						st_r != 4'(ST_IDLE)};
					default: sw_rdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	sequence poll_pair_s;
		(st_r == 4'(ST_POLL_A)) ##[1:20] (st_r == 4'(ST_POLL_B));
	endsequence
	sequence reset_cmd_s;
		(st_r == 4'(ST_RESET)) && cyc.wr && (cyc.wdata == CMD_RESET) && (cyc.addr == ADDR_RST);
	endsequence

	poll_addr_a: assert property (@(posedge core_clk) disable iff (rst) // see (R2) // see (R5)
		(req_r && !cyc.wr) |-> (cyc.addr == op_addr_r))
		else $error("status read away from operation address");
	fetch_order_a: assert property (@(posedge core_clk) disable iff (rst) // see (R9)
		((st_r == 4'(ST_FETCH)) && ($past(st_r) != 4'(ST_FETCH)) && (op_r != OP_READ))
		|-> ($past(st_r) == 4'(ST_POLL_B)) || ($past(st_r) == 4'(ST_RECHK_B)))
		else $error("array fetch without toggle check");
	stop_done_a: assert property (@(posedge core_clk) disable iff (rst) // see (R17)
		((st_r == 4'(ST_POLL_B)) && cyc.done && same_tog) |=> (st_r == 4'(ST_FETCH)) && req_r)
		else $error("stopped toggle not taken as complete");
	timeout_rechk_a: assert property (@(posedge core_clk) disable iff (rst) // see (R18)
		((st_r == 4'(ST_POLL_B)) && cyc.done && !same_tog && cyc.rdata[TIMEOUT_EXCEEDED_POS])
		|=> (st_r == 4'(ST_RECHK_A)) ##[1:30] ((st_r == 4'(ST_RECHK_B)) && cyc.done))
		else $error("timeout not rechecked");
	fail_reset_a: assert property (@(posedge core_clk) disable iff (rst) // see (R22)
		((st_r == 4'(ST_RECHK_B)) && cyc.done && !same_tog) |=> reset_cmd_s ##[1:20] fail_r)
		else $error("failure without reset command");
	resume_restart_a: assert property (@(posedge core_clk) disable iff (rst) // see (R19)
		((st_r == 4'(ST_PAUSE)) && !hold_r) |=> (st_r == 4'(ST_POLL_A)) && req_r)
		else $error("resume skipped first read");
	pair_first_a: assert property (@(posedge core_clk) disable iff (rst) // see (R17)
		((st_r == 4'(ST_POLL_B)) && cyc.done && !same_tog && !cyc.rdata[TIMEOUT_EXCEEDED_POS])
		|=> (st_r == 4'(ST_POLL_A)) || (st_r == 4'(ST_PAUSE)))
		else $error("toggling poll left the loop");
	cmd_then_poll_a: assert property (@(posedge core_clk) disable iff (rst) // see (R8)
		((st_r == 4'(ST_CMD)) && cyc.done && step_w[38] && (op_r != OP_RESET))
		|=> (st_r == 4'(ST_POLL_A)) ##1 (!flash_ce_n)[*3])
		else $error("poll not started after final strobe");
endmodule : fwsr_host
`default_nettype wire

// file: design/fwsr_pkg.sv
// Shared constants and types for the flash write-status polling controller.
package fwsr_pkg;
	// --------------------------------------------------------------
	// Timing
	// --------------------------------------------------------------
	localparam int CLK_NS = 10;
	localparam int T_ACC_NS = 60;
	localparam int T_WP_NS = 35;
	localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
	localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int SYNC_CYC = 2;
	localparam int RD_CYC = ACC_CYC + SYNC_CYC;
	localparam logic [3:0] RD_LAST = 4'(RD_CYC - 1);
	localparam logic [3:0] WP_LAST = 4'(WP_CYC - 1);

	// --------------------------------------------------------------
	// Software register map
	// --------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_DATA = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0c;
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_GO_BIT = 3;
	localparam int CTRL_HOLD_BIT = 4;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int STAT_FAIL_BIT = 2;
	localparam int STAT_READY_BIT = 3;
	localparam int STAT_HOLD_BIT = 4;
	localparam logic [21:0] ADDR_RST = 22'h000000;
	localparam logic [15:0] DATA_RST = 16'h0000;

	// --------------------------------------------------------------
	// Status lane positions and command words
	// --------------------------------------------------------------
	localparam int TOGGLE_BIT_ONE_POS = 6;
	localparam int TIMEOUT_EXCEEDED_POS = 5;
	localparam logic [21:0] UNLOCK_A1 = 22'h000555;
	localparam logic [21:0] UNLOCK_A2 = 22'h0002aa;
	localparam logic [15:0] UNLOCK_D1 = 16'h00aa;
	localparam logic [15:0] UNLOCK_D2 = 16'h0055;
	localparam logic [15:0] CMD_PROGRAM = 16'h00a0;
	localparam logic [15:0] CMD_ERASE_SETUP = 16'h0080;
	localparam logic [15:0] CMD_SECTOR_ERASE = 16'h0030;
	localparam logic [15:0] CMD_RESET = 16'h00f0;

	typedef enum logic [1:0] {
		OP_READ,
		OP_PROGRAM,
		OP_ERASE,
		OP_RESET
	} fwsr_op_t;
endpackage : fwsr_pkg

// file: design/fwsr_cyc_if.sv
// One-bus-cycle request channel between the sequencer and the pin engine.
`timescale 1ns/1ps
`default_nettype none
interface fwsr_cyc_if;
	logic req;
	logic wr;
	logic [21:0] addr;
	logic [15:0] wdata;
	logic done;
	logic [15:0] rdata;
	modport ctl (output req, output wr, output addr, output wdata, input done, input rdata);
	modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface : fwsr_cyc_if
`default_nettype wire

// file: design/fwsr_bus_cycle.sv
// Pin engine: runs one asynchronous read or write cycle on the flash bus.
`timescale 1ns/1ps
`default_nettype none
module fwsr_bus_cycle (
	input wire logic core_clk, // System clock.
	input wire logic rst, // Asynchronous reset, active high.
	fwsr_cyc_if.eng cyc, // Cycle request channel.
	output logic [21:0] flash_addr, // Address pins.
	output logic [15:0] flash_dq_o, // Data pins, driven value.
	output logic flash_dq_oe, // Data pins, output enable.
	input wire logic [15:0] flash_dq_i, // Data pins, sensed value.
	output logic flash_ce_n, // Chip enable, active low.
	output logic flash_oe_n, // Output enable, active low.
	output logic flash_we_n // Write enable, active low.
);
	import fwsr_pkg::*;

	typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD} fwsr_cst_t;
	fwsr_cst_t cst_r;
	logic wr_r;
	logic [3:0] cnt_r;
	logic [15:0] dq_s1_r;
	logic [15:0] dq_s2_r;

	// --------------------------------------------------------------
	// Input synchroniser
	// --------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			dq_s1_r <= DATA_RST;
			dq_s2_r <= DATA_RST;
		end else begin
			dq_s1_r <= flash_dq_i;
			dq_s2_r <= dq_s1_r;
		end
	end

	// --------------------------------------------------------------
	// Cycle sequencing
	// --------------------------------------------------------------
	// Read strobes stay low long enough for access time plus the synchroniser.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cst_r <= C_IDLE;
			cnt_r <= 4'h0;
			wr_r <= 1'b0;
			flash_addr <= ADDR_RST;
			flash_dq_o <= DATA_RST;
			cyc.rdata <= DATA_RST;
		end else begin
			case (cst_r)
				C_IDLE: begin
					if (cyc.req) begin
						wr_r <= cyc.wr;
						flash_addr <= cyc.addr;
						flash_dq_o <= cyc.wdata;
						cst_r <= C_SETUP;
					end
				end
				C_SETUP: begin
					cnt_r <= 4'h0;
					cst_r <= C_STROBE;
				end
				C_STROBE: begin
					cnt_r <= cnt_r + 4'h1;
					if (cnt_r == (wr_r ? WP_LAST : RD_LAST)) begin
						if (!wr_r) begin
							cyc.rdata <= dq_s2_r;
						end
						cst_r <= C_HOLD;
					end
				end
				C_HOLD: cst_r <= C_IDLE;
				default: cst_r <= C_IDLE;
			endcase
		end
	end

	assign cyc.done = (cst_r == C_HOLD);
	assign flash_ce_n = (cst_r == C_IDLE);
	assign flash_oe_n = !((cst_r == C_STROBE) && !wr_r);
	assign flash_we_n = !((cst_r == C_STROBE) && wr_r);
	assign flash_dq_oe = wr_r && (cst_r != C_IDLE);

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	wr_pulse_width_a: assert property (@(posedge core_clk) disable iff (rst)
		$fell(flash_we_n) |-> (!flash_we_n)[*4] ##1 flash_we_n)
		else $error("write strobe width wrong");
	rd_no_drive_a: assert property (@(posedge core_clk) disable iff (rst)
		!flash_oe_n |-> !flash_dq_oe)
		else $error("data pins driven during read");
endmodule : fwsr_bus_cycle
`default_nettype wire

// file: bench/fwsr_flash_model.sv
// Behavioural model of the flash device seen from the host controller.
`timescale 1ns/1ps
`default_nettype none
module fwsr_flash_model (
	input wire logic [21:0] flash_addr, // Address pins.
	input wire logic [15:0] flash_dq_o, // Data driven by the host.
	input wire logic flash_dq_oe, // Host drives the data pins.
	output logic [15:0] flash_dq_i, // Data seen by the host.
	input wire logic flash_ce_n, // Chip enable.
	input wire logic flash_oe_n, // Output enable.
	input wire logic flash_we_n, // Write enable.
	output logic ready_busy_n // Ready/busy, low while busy.
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	localparam logic [6:0] PROT_SECT = 7'h7f;
	localparam int PROT_READS = 3;
	logic [15:0] mem [logic [21:0]];
	int busy_reads = 0;
	int left = 0;
	int step = 0;
	int n_bad = 0;
	int n_reset = 0;
	logic is_erase = 1'b0;
	logic susp = 1'b0;
	logic fail_pend = 1'b0;
	logic fail = 1'b0;
	logic tog1 = 1'b0;
	logic tog2 = 1'b0;
	logic [21:0] op_addr = 22'h000000;
	logic [15:0] op_data = 16'h0000;
	logic [15:0] out_r = 16'h0000;
	logic [15:0] last = 16'h0000;

	function automatic logic [15:0] rd(input logic [21:0] a);
		return mem.exists(a) ? mem[a] : 16'hffff;
	endfunction : rd

	function automatic logic hit(input logic [21:0] a, input logic [7:0] d);
		return flash_addr == a && flash_dq_o[7:0] == d;
	endfunction : hit

	task automatic start(input logic er);
		is_erase = er;
		op_addr = flash_addr;
		op_data = flash_dq_o;
		fail_pend = 1'b0;
		if (op_addr[21:15] == PROT_SECT) begin
			left = PROT_READS;
		end else begin
			left = busy_reads;
			if (er) begin
				foreach (mem[k]) begin
					if (k[21:15] == op_addr[21:15]) mem[k] = 16'hffff;
				end
			end else if (|(op_data & ~rd(op_addr))) begin
				fail_pend = 1'b1;
			end else begin
				mem[op_addr] = rd(op_addr) & op_data;
			end
		end
		if (fail_pend && left == 0) fail = 1'b1;
	endtask : start

	// ------------------------------------------------------------
	// Command decode on the closing write strobe edge
	// ------------------------------------------------------------
	always @(posedge flash_we_n) begin
		if (!flash_ce_n) begin
			if (!flash_dq_oe) n_bad++;
			if (flash_dq_o[7:0] == 8'hf0 && step != 3) begin
				step = 0;
				left = 0;
				fail = 1'b0;
				fail_pend = 1'b0;
				n_reset++;
			end else begin
				case (step)
					0, 4: step = hit(22'h000555, 8'haa) ? step + 1 : 9;
					1, 5: step = hit(22'h0002aa, 8'h55) ? step + 1 : 9;
					2: step = hit(22'h000555, 8'ha0) ? 3 : hit(22'h000555, 8'h80) ? 4 : 9;
					3: begin
						start(1'b0);
						step = 0;
					end
					6: begin
						step = (flash_dq_o[7:0] == 8'h30) ? 0 : 9;
						start(1'b1);
					end
					default: step = 9;
				endcase
				if (step == 9) begin
					n_bad++;
					step = 0;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Read cycles: status while busy or suspended, array data otherwise
	// ------------------------------------------------------------
	always @(negedge flash_oe_n) begin
		if (!flash_ce_n) begin
			if (left > 0 || fail) begin
				if (!susp) tog1 = ~tog1;
				if (is_erase && flash_addr[21:15] == op_addr[21:15]) tog2 = ~tog2;
				if (is_erase ? flash_addr[21:15] != op_addr[21:15] : flash_addr != op_addr) n_bad++;
				out_r = 16'h0000;
				out_r[7] = is_erase ? susp : ~op_data[7];
				out_r[6] = tog1;
				out_r[5] = fail;
				out_r[2] = tog2;
				if (left > 0 && !susp) begin
					left--;
					if (left == 0 && fail_pend) fail = 1'b1;
				end
			end else begin
				out_r = rd(flash_addr);
			end
		end
	end

	// A released bus shows the inverse of the last value, never a stale match.
	always @(posedge flash_oe_n) last = out_r;
	assign flash_dq_i = (!flash_ce_n && !flash_oe_n) ? out_r : ~last;
	assign ready_busy_n = !((left > 0 && !susp) || fail);
endmodule : fwsr_flash_model
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking testbench for the flash write-status host controller.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import fwsr_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] sw_addr = 8'h00;
	logic [31:0] sw_wdata = 32'h00000000;
	logic sw_wr = 1'b0;
	logic sw_rd = 1'b0;
	logic [31:0] sw_rdata;
	logic [21:0] flash_addr;
	logic [15:0] flash_dq_o;
	logic flash_dq_oe;
	logic [15:0] flash_dq_i;
	logic flash_ce_n;
	logic flash_oe_n;
	logic flash_we_n;
	logic ready_busy_n;
	int error_cnt = 0;
	int n_compared = 0;
	int r;

	always #5 core_clk = ~core_clk;

	fwsr_host fwsr_host_i (.core_clk(core_clk), .rst(rst), .sw_addr(sw_addr),
		.sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
		.flash_addr(flash_addr), .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe),
		.flash_dq_i(flash_dq_i), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
		.flash_we_n(flash_we_n), .ready_busy_n(ready_busy_n));

	fwsr_flash_model fwsr_flash_model_i (.flash_addr(flash_addr), .flash_dq_o(flash_dq_o),
		.flash_dq_oe(flash_dq_oe), .flash_dq_i(flash_dq_i), .flash_ce_n(flash_ce_n),
		.flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .ready_busy_n(ready_busy_n));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic test_done;
		if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : test_done

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic sw_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge core_clk);
		sw_wr <= 1'b0;
	endtask : sw_write

	task automatic sw_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge core_clk);
		sw_rd <= 1'b0;
		#1 d = sw_rdata;
	endtask : sw_read

	task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		sw_read(a, d);
		chk(d, exp);
	endtask : expect_reg

	task automatic wait_idle;
		logic [31:0] s;
		int i;
		for (i = 0; i < 3000; i++) begin
			sw_read(REG_STAT, s);
			if (s[STAT_BUSY_BIT] === 1'b0) break;
		end
		if (i == 3000) begin
			error_cnt++;
			test_done();
		end
	endtask : wait_idle

	task automatic run_op(input fwsr_op_t op, input logic [21:0] a, input logic [15:0] d);
		sw_write(REG_ADDR, {10'h000, a});
		sw_write(REG_DATA, {16'h0000, d});
		sw_write(REG_CTRL, 32'(op) | (32'h1 << CTRL_GO_BIT));
		wait_idle();
	endtask : run_op

	task automatic expect_mem(input logic [21:0] a, input logic [15:0] exp);
		chk({16'h0000, fwsr_flash_model_i.rd(a)}, {16'h0000, exp});
	endtask : expect_mem

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic s_after_reset;
		expect_reg(REG_STAT, 32'h00000008);
		expect_reg(8'h10, 32'h00000000);
		expect_reg(REG_ADDR, 32'h00000000);
	endtask : s_after_reset

	task automatic s_program(input int lat, input logic [21:0] a, input logic [15:0] d);
		fwsr_flash_model_i.busy_reads = lat;
		run_op(OP_PROGRAM, a, d);
		expect_reg(REG_STAT, 32'h0000000a);
		expect_reg(REG_DATA, {16'h0000, d});
		expect_mem(a, d);
	endtask : s_program

	task automatic s_hold;
		fwsr_flash_model_i.busy_reads = 20;
		sw_write(REG_ADDR, 32'h00000200);
		sw_write(REG_DATA, 32'h000000c3);
		sw_write(REG_CTRL, 32'(OP_PROGRAM) | (32'h1 << CTRL_GO_BIT) | (32'h1 << CTRL_HOLD_BIT));
		repeat (100) @(posedge core_clk);
		expect_reg(REG_STAT, 32'h00000011);
		sw_write(REG_CTRL, 32'h00000000);
		wait_idle();
		expect_reg(REG_STAT, 32'h0000000a);
		expect_reg(REG_DATA, 32'h000000c3);
	endtask : s_hold

	task automatic s_suspend;
		logic [31:0] d;
		fwsr_flash_model_i.busy_reads = 40;
		fwsr_flash_model_i.susp = 1'b1;
		run_op(OP_ERASE, 22'h000100, 16'h0000);
		expect_reg(REG_STAT, 32'h0000000a);
		sw_read(REG_DATA, d);
		chk({31'h0, d[7]}, 32'h00000001);
		fwsr_flash_model_i.susp = 1'b0;
		fwsr_flash_model_i.left = 0;
	endtask : s_suspend

	task automatic s_read_op;
		run_op(OP_READ, 22'h000124, 16'h0000);
		expect_reg(REG_DATA, 32'h00001234);
	endtask : s_read_op

	task automatic s_timeout;
		logic [31:0] s;
		fwsr_flash_model_i.busy_reads = 4;
		r = fwsr_flash_model_i.n_reset;
		run_op(OP_PROGRAM, 22'h000123, 16'hffff);
		sw_read(REG_STAT, s);
		chk({31'h0, s[STAT_FAIL_BIT]}, 32'h00000001);
		chk(32'(fwsr_flash_model_i.n_reset), 32'(r + 1));
		expect_mem(22'h000123, 16'h5a3c);
	endtask : s_timeout

	task automatic s_protect;
		run_op(OP_PROGRAM, 22'h3f8000, 16'h0000);
		expect_reg(REG_STAT, 32'h0000000a);
		expect_reg(REG_DATA, 32'h0000ffff);
		expect_mem(22'h3f8000, 16'hffff);
	endtask : s_protect

	task automatic s_erase;
		fwsr_flash_model_i.busy_reads = 7;
		run_op(OP_ERASE, 22'h000100, 16'h0000);
		expect_reg(REG_STAT, 32'h0000000a);
		expect_reg(REG_DATA, 32'h0000ffff);
		expect_mem(22'h000123, 16'hffff);
		expect_mem(22'h000124, 16'hffff);
	endtask : s_erase

	task automatic s_reset_op;
		r = fwsr_flash_model_i.n_reset;
		run_op(OP_RESET, 22'h000000, 16'h0000);
		chk(32'(fwsr_flash_model_i.n_reset), 32'(r + 1));
	endtask : s_reset_op

	initial begin
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		s_after_reset();
		s_program(5, 22'h000123, 16'h5a3c);
		s_program(0, 22'h000124, 16'h1234);
		s_hold();
		s_read_op();
		s_timeout();
		s_protect();
		s_erase();
		s_suspend();
		s_reset_op();
		chk(32'(fwsr_flash_model_i.n_bad), 32'h00000000);
		test_done();
	end
endmodule : tb_top
`default_nettype wire
